// *** logic/lc_logic_cell.sv ***
// Configurable logic cell: two 4-input tables, a 3-input combiner,
// two flip-flops, dedicated carry and two distributed RAM modes.
// Assumes configuration inputs are static while the cell runs and
// that the surrounding logic drives all inputs synchronously.
//
// Operation
// - F and G tables each index from their own four input pins; in 32x1 mode G uses the F pins.
// - Combiner merges F, G and extra input for any five-input function.
// - Each flip-flop may capture a table output or the direct data input.
// - With combiner bypassed, extra input feeds the flip-flops straight through.
// - Separate combinational and registered output pairs work independently.
// - Carry logic makes carries; tables form sums; two bits or one.
// - Carry chain runs upward or downward through a column of cells.
// - In memory mode the F and G tables become writable storage.
// - In memory mode table input pins are the address lines.
// - 16x2: separate memories, direct data and extra input as write bits.
// - 32x1: merged via combiner, direct data writes, upper pin is address bit.
// - In both memory modes the set/reset pin is the write enable.
// - 16x2 reads at F and G outputs; 32x1 reads at combiner output.
// - Read data drives combinational outputs or is registered as in logic.
// - In 16x2 mode the combiner still computes any function of reads.
// - In 32x1 mode flip-flops can capture write data or read data.

`timescale 1ns/1ps

module lc_logic_cell
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Static configuration
    input wire lc_pkg::lc_mode_t i_cfg_mode,
    input wire logic [15:0] i_cfg_f_table,
    input wire logic [15:0] i_cfg_g_table,
    input wire logic [7:0] i_cfg_h_table,
    input wire logic i_cfg_h_bypass,
    input wire lc_pkg::lc_src_t i_cfg_x_src,
    input wire lc_pkg::lc_src_t i_cfg_y_src,
    input wire logic i_cfg_x_from_comb,
    input wire logic i_cfg_y_from_comb,
    input wire logic i_cfg_arith_en,
    input wire logic i_cfg_arith_two,
    input wire logic i_cfg_carry_up,
    // Cell inputs
    input wire logic [3:0] i_f_in,
    input wire logic [3:0] i_g_in,
    input wire logic i_combiner_extra_input,
    input wire logic i_upper_address_bit,
    input wire logic i_din,
    input wire logic i_sr,
    input wire logic i_ce,
    // Carry chain
    input wire logic i_carry_from_below,
    input wire logic i_carry_from_above,
    output logic o_carry_to_above,
    output logic o_carry_to_below,
    // Results
    output logic o_x,
    output logic o_y,
    output logic o_xq,
    output logic o_yq
);
    import lc_pkg::*;

    // ========================================
    // State and decode
    lc_state_t st_reg;
    lc_state_t st_next;
    logic ram_on;
    logic ram16;
    logic ram32;
    logic arith;
    logic we;
    logic [LC_IDX_W-1:0] f_idx;
    logic [LC_IDX_W-1:0] g_idx;
    logic [2:0] h_idx;
    logic [LC_TABLE_BITS-1:0] f_tab;
    logic [LC_TABLE_BITS-1:0] g_tab;
    logic f_out;
    logic g_out;
    logic h_out;
    logic carry_in;
    logic carry_mid;
    logic carry_out;

    // Mode decode; set/reset pin doubles as write enable in memory modes
    assign ram16 = (i_cfg_mode == LC_MODE_RAM16X2);
    assign ram32 = (i_cfg_mode == LC_MODE_RAM32X1);
    assign ram_on = ram16 | ram32;
    assign we = ram_on & i_sr;
    // Arithmetic steals table inputs, so it is off in memory modes
    assign arith = i_cfg_arith_en & ~ram_on;

    // ========================================
    // Dedicated carry path
    // Direction picks which neighbour feeds the chain
    assign carry_in = i_cfg_carry_up ? i_carry_from_below : i_carry_from_above;
    // Bit 0 operands on F pins 0/1, bit 1 operands on G pins 0/1
    assign carry_mid = (i_f_in[0] & i_f_in[1])
                     | (carry_in & (i_f_in[0] ^ i_f_in[1]));
    assign carry_out = i_cfg_arith_two
                     ? ((i_g_in[0] & i_g_in[1]) | (carry_mid & (i_g_in[0] ^ i_g_in[1])))
                     : carry_mid;
    // Only the selected end drives; the other stays low
    assign o_carry_to_above = arith & i_cfg_carry_up & carry_out;
    assign o_carry_to_below = arith & ~i_cfg_carry_up & carry_out;

    // ========================================
    // Table addressing
    // Carry replaces pin 2 so the table forms the sum bit
    always_comb
    begin
        f_idx = i_f_in;
        g_idx = i_g_in;
        if (arith)
        begin
            f_idx = {i_f_in[3], carry_in, i_f_in[1:0]};
            if (i_cfg_arith_two)
            begin
                g_idx = {i_g_in[3], carry_mid, i_g_in[1:0]};
            end
        end
        else if (ram32)
        begin
            // Both halves share one four-bit word address
            g_idx = i_f_in;
        end
    end

    // ========================================
    // Look-up generators
    // Memory modes read stored contents, logic mode reads configuration
    assign f_tab = ram_on ? st_reg.f_ram : i_cfg_f_table;
    assign g_tab = ram_on ? st_reg.g_ram : i_cfg_g_table;
    assign f_out = f_tab[f_idx];
    assign g_out = g_tab[g_idx];
    assign h_idx = {i_combiner_extra_input, g_out, f_out};

    // Combiner: merged read, pass-through or free function
    always_comb
    begin
        if (ram32)
        begin
            h_out = i_upper_address_bit ? g_out : f_out;
        end
        else if (i_cfg_h_bypass)
        begin
            h_out = i_combiner_extra_input;
        end
        else
        begin
            h_out = i_cfg_h_table[h_idx];
        end
    end

    // ========================================
    // Combinational outputs
    // Left unregistered so table results are usable in the same cycle
    assign o_x = i_cfg_x_from_comb ? h_out : f_out;
    assign o_y = i_cfg_y_from_comb ? h_out : g_out;

    // ========================================
    // Next state
    always_comb
    begin
        st_next = st_reg;
        // Logic mode keeps storage loaded so a switch to memory starts known
        if (!ram_on)
        begin
            st_next.f_ram = i_cfg_f_table;
            st_next.g_ram = i_cfg_g_table;
        end
        // Writes land on the clock edge, so narrow enable glitches are absorbed
        else if (we)
        begin
            if (ram16)
            begin
                st_next.f_ram[f_idx] = i_din;
                st_next.g_ram[g_idx] = i_combiner_extra_input;
            end
            else if (i_upper_address_bit)
            begin
                st_next.g_ram[g_idx] = i_din;
            end
            else
            begin
                st_next.f_ram[f_idx] = i_din;
            end
        end

        // Flip-flops: set/reset clears only in logic mode
        if (!ram_on && i_sr)
        begin
            st_next.x_q = LC_FF_CLEAR;
            st_next.y_q = LC_FF_CLEAR;
        end
        else if (i_ce)
        begin
            case (i_cfg_x_src)
                LC_SRC_LUT: st_next.x_q = f_out;
                LC_SRC_COMB: st_next.x_q = h_out;
                LC_SRC_DIN: st_next.x_q = i_din;
                default: st_next.x_q = st_reg.x_q;
            endcase
            case (i_cfg_y_src)
                LC_SRC_LUT: st_next.y_q = g_out;
                LC_SRC_COMB: st_next.y_q = h_out;
                LC_SRC_DIN: st_next.y_q = i_din;
                default: st_next.y_q = st_reg.y_q;
            endcase
        end
    end

    // ========================================
    // State register
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            st_reg <= LC_STATE_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Registered outputs
    assign o_xq = st_reg.x_q;
    assign o_yq = st_reg.y_q;

    // ========================================
    // Checks
    // 16x2 write stores both bits at the addressed words
    a_ram16_write_pair:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (ram16 && i_sr) |=> (st_reg.f_ram[$past(f_idx)] == $past(i_din))
                         && (st_reg.g_ram[$past(g_idx)] == $past(i_combiner_extra_input)))
    else $error("16x2 write did not store data");

    // 32x1 write with the upper bit set hits only the G half
    a_ram32_write_half:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (ram32 && i_sr && i_upper_address_bit)
        |=> (st_reg.g_ram[$past(g_idx)] == $past(i_din)) && $stable(st_reg.f_ram))
    else $error("32x1 write touched wrong half");

    // Without write enable memory contents hold
    a_ram_hold_idle:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (ram_on && !i_sr) ##1 ram_on |-> $stable(st_reg.f_ram) && $stable(st_reg.g_ram))
    else $error("memory changed without write enable");

    // Merged read follows the upper address bit
    a_ram32_read_sel:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (ram32 && i_cfg_x_from_comb)
        |-> o_x == (i_upper_address_bit ? st_reg.g_ram[i_f_in] : st_reg.f_ram[i_f_in]))
    else $error("32x1 read data wrong");

    // Direct data captured into the X flip-flop
    a_ffx_din_take:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && (ram_on || !i_sr) && i_cfg_x_src == LC_SRC_DIN) |=> o_xq == $past(i_din))
    else $error("X flip-flop missed direct data");

    // Bypassed combiner carries extra input to the Y flip-flop
    a_ffy_bypass_take:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && !i_sr && !ram32 && i_cfg_h_bypass && i_cfg_y_src == LC_SRC_COMB)
        |=> o_yq == $past(i_combiner_extra_input))
    else $error("Y flip-flop missed bypassed input");

    // Set/reset in logic mode clears both flip-flops, two cycles held
    a_logic_sr_clear:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (!ram_on && i_sr)[*2] |=> !o_xq && !o_yq ##0 $past(o_xq) == 1'b0)
    else $error("flip-flops not cleared");

    // Full two-bit generate on an upward chain always carries out to the upper neighbour
    a_carry_generate:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (arith && i_cfg_arith_two && i_cfg_carry_up && (&i_g_in[1:0]))
        |-> o_carry_to_above && !o_carry_to_below)
    else $error("carry generate lost");

    // Downward chain never drives the upper neighbour
    a_carry_dir_down:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !i_cfg_carry_up |-> !o_carry_to_above)
    else $error("carry left in wrong direction");

endmodule // lc_logic_cell

// *** logic/lc_pkg.sv ***
// Shared types and constants for the configurable logic cell.
// Assumes a single clock domain and configuration inputs held static.

package lc_pkg;

    // ========================================
    // Table geometry
    localparam int LC_TABLE_BITS = 16;
    localparam int LC_IDX_W = 4;
    localparam int LC_COMB_BITS = 8;

    // ========================================
    // Operating arrangements of the cell
    typedef enum logic [1:0]
    {
        LC_MODE_LOGIC,
        LC_MODE_RAM16X2,
        LC_MODE_RAM32X1
    } lc_mode_t;

    // Flip-flop data source selection
    typedef enum logic [1:0]
    {
        LC_SRC_LUT,
        LC_SRC_COMB,
        LC_SRC_DIN
    } lc_src_t;

    // ========================================
    // Complete cell state
    typedef struct packed
    {
        logic [LC_TABLE_BITS-1:0] f_ram;
        logic [LC_TABLE_BITS-1:0] g_ram;
        logic x_q;
        logic y_q;
    } lc_state_t;

    // Value after reset: tables empty, both flip-flops low
    localparam lc_state_t LC_STATE_RESET = '0;
    localparam logic LC_FF_CLEAR = 1'b0;

endpackage

// *** tb/lc_user_model.sv ***
// Model of the user logic that drives the cell's write enable.
// Assumes the bench sets the request between a rising and a falling edge.
`timescale 1ns/1ps
module lc_user_model
(
    // Clock and request
    input wire logic i_clk,
    input wire logic i_we_req,
    // Enable towards the cell
    output logic o_we
);
    // ========================================
    // Output stage
    initial o_we = 1'b0;
    // Launched from a register only, so the enable cannot glitch mid-cycle
    always @(negedge i_clk)
    begin
        o_we <= i_we_req;
    end
endmodule // lc_user_model

// *** tb/tb_top.sv ***
// Self-checking bench for the logic cell: logic, carry and both RAM modes.
// Assumes the partner model drives write enable; all else at falling edges.
`timescale 1ns/1ps
module tb_top;
    import lc_pkg::*;
    // ========================================
    // Stimulus and observed signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    lc_mode_t mode = LC_MODE_LOGIC;
    lc_src_t xs = LC_SRC_DIN;
    lc_src_t ys = LC_SRC_COMB;
    logic [15:0] ft = '0, gt = '0;
    logic [7:0] ht = '0;
    logic [3:0] fi = '0, gi = '0;
    logic [4:0] fa, ga;
    logic hb = 0, xfc = 0, yfc = 0, ae = 0, a2 = 1, cu = 1, e = 0, ua = 0, din = 0, ce = 1, cb = 0, ca = 0;
    logic we_req = 0;
    logic we, cta, ctb, ox, oy, oxq, oyq, cin, c1, co, rf, hv, xv, yv;
    logic m [32];
    int n_errors = 0, checks_done = 0, seed;

    // Free-running 250 MHz clock
    always #2 clk = ~clk;

    lc_user_model u_user (.i_clk(clk), .i_we_req(we_req), .o_we(we));

    lc_logic_cell DUT (.i_clk(clk), .i_reset_n(rst_n), .i_cfg_mode(mode), .i_cfg_f_table(ft),
        .i_cfg_g_table(gt), .i_cfg_h_table(ht), .i_cfg_h_bypass(hb), .i_cfg_x_src(xs), .i_cfg_y_src(ys),
        .i_cfg_x_from_comb(xfc), .i_cfg_y_from_comb(yfc), .i_cfg_arith_en(ae), .i_cfg_arith_two(a2),
        .i_cfg_carry_up(cu), .i_f_in(fi), .i_g_in(gi), .i_combiner_extra_input(e), .i_upper_address_bit(ua),
        .i_din(din), .i_sr(we), .i_ce(ce), .i_carry_from_below(cb), .i_carry_from_above(ca),
        .o_carry_to_above(cta), .o_carry_to_below(ctb), .o_x(ox), .o_y(oy), .o_xq(oxq), .o_yq(oyq));

    // ========================================
    // Helpers
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Let the rising edge land before looking
    task go;
        @(posedge clk);
        #1;
    endtask

    function automatic logic maj(input logic a, input logic b, input logic c);
        return (a & b) | (a & c) | (b & c);
    endfunction

    // Flip-flop capture expected from the chosen source
    function automatic logic ff_e(input lc_src_t s, input logic lut, input logic h, input logic d);
        case (s)
            LC_SRC_LUT: return lut;
            LC_SRC_COMB: return h;
            default: return d;
        endcase
    endfunction

    // Combiner value expected from the model memory
    function automatic logic comb_e();
        if (mode == LC_MODE_RAM32X1)
            return m[fa];
        return hb ? e : ht[{e, m[ga], m[fa]}];
    endfunction

    // Fill every word, then mix random reads and writes
    task ram_test(input lc_mode_t md);
        for (int i = 0; i < 96; i++)
        begin
            we_req = (i < 32) ? 1'b1 : 1'($urandom);
            @(negedge clk);
            mode = md;
            ae = 1'b0;
            {ua, fi} = (i < 32) ? 5'(i) : 5'($urandom);
            gi = (i < 32) ? 4'(i) : 4'($urandom);
            {e, din, hb} = 3'($urandom);
            xfc = (md == LC_MODE_RAM32X1) ? 1'b1 : 1'($urandom);
            xs = (md == LC_MODE_RAM32X1) ? LC_SRC_DIN : LC_SRC_LUT;
            fa = {md == LC_MODE_RAM32X1 && ua, fi};
            ga = {1'b1, gi};
            rf = m[fa];
            hv = comb_e();
            #1;
            if (i >= 32) chk(ox, xfc ? hv : rf);
            go;
            if (we_req)
            begin
                m[fa] = din;
                if (md == LC_MODE_RAM16X2) m[ga] = e;
            end
            if (i >= 32)
            begin
                chk(ox, xfc ? comb_e() : m[fa]);
                if (md == LC_MODE_RAM16X2) chk(oy, m[ga]);
                chk(oxq, (md == LC_MODE_RAM32X1) ? din : rf);
                chk(oyq, hv);
            end
        end
        $display("test memory mode %0d done", md);
    endtask

    // ========================================
    // Main sequence
    initial
    begin
        seed = $urandom(32'h688b782f);
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        ft = 16'($urandom);
        gt = 16'($urandom);
        ht = 8'($urandom);
        go;
        for (int k = 0; k < 40; k++)
        begin
            // Set/reset is requested early so the partner launches it at the falling edge
            we_req = (k == 20 || k == 21) ? 1'b1 : 1'($urandom);
            @(negedge clk);
            fi = 4'($urandom);
            gi = 4'($urandom);
            {e, din, hb, xfc, yfc, ce} = 6'($urandom);
            xs = lc_src_t'(2'($urandom_range(2)));
            ys = lc_src_t'(2'($urandom_range(2)));
            xv = oxq;
            yv = oyq;
            go;
            hv = hb ? e : ht[{e, gt[gi], ft[fi]}];
            chk(ox, xfc ? hv : ft[fi]);
            chk(oy, yfc ? hv : gt[gi]);
            chk(oxq, we_req ? 1'b0 : (ce ? ff_e(xs, ft[fi], hv, din) : xv));
            chk(oyq, we_req ? 1'b0 : (ce ? ff_e(ys, gt[gi], hv, din) : yv));
        end
        $display("test logic done");
        // Back to plain capture; later tests rely on enabled flip-flops and no clear
        we_req = 1'b0;
        @(negedge clk);
        ft = 16'h9696;
        gt = 16'h9696;
        {ae, xfc, yfc, ce} = 4'b1001;
        ys = LC_SRC_COMB;
        go;
        repeat (32)
        begin
            @(negedge clk);
            fi = 4'($urandom);
            gi = 4'($urandom);
            {a2, cu, cb, ca} = 4'($urandom);
            #1;
            cin = cu ? cb : ca;
            c1 = maj(fi[0], fi[1], cin);
            // One-bit arithmetic leaves G a plain table and carries out of bit 0
            co = a2 ? maj(gi[0], gi[1], c1) : c1;
            chk(ox, fi[0] ^ fi[1] ^ cin);
            chk(oy, gi[0] ^ gi[1] ^ (a2 ? c1 : gi[2]));
            chk({cta, ctb}, cu ? {co, 1'b0} : {1'b0, co});
            go;
        end
        $display("test carry done");
        ram_test(LC_MODE_RAM16X2);
        ram_test(LC_MODE_RAM32X1);
        close_out;
    end

    // Watchdog: the tests need about 300 cycles
    initial
    begin
        repeat (3000) @(posedge clk);
        n_errors++;
        close_out;
    end
endmodule // tb_top
